//--- bit_sync.sv
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clk_i; reset value is the idle level
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int W = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '1;
      sync_q <= '1;
    end else if (ce_i) begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : bit_sync
`default_nettype wire

//--- conv_duration.sv
// conversion phase length lookup by oversampling code
// assumes a legal code 000..101; pressure phase is total minus temperature
`timescale 1ns/1ps
`default_nettype none
`include "sensor_seq_params.svh"
module conv_duration #(
  parameter int unsigned TEMP_CYC [6] = '{6{1}},
  parameter int unsigned BOTH_CYC [6] = '{6{2}}
) (
  input wire logic [2:0] ovs_i,
  input wire logic press_phase_i,
  output logic [`CNT_W-1:0] limit_o
);
  int unsigned t_cyc;
  int unsigned b_cyc;

  always_comb begin
    t_cyc = TEMP_CYC[0];
    b_cyc = BOTH_CYC[0];
    for (int i = 0; i < 6; i++) begin
      if (ovs_i == 3'(i)) begin
        t_cyc = TEMP_CYC[i];
        b_cyc = BOTH_CYC[i];
      end
    end
    if (press_phase_i) begin
      limit_o = `CNT_W'(b_cyc - t_cyc - 1); // RULE14
    end else begin
      limit_o = `CNT_W'(t_cyc - 1); // RULE14
    end
  end
endmodule : conv_duration
`default_nettype wire

//--- sensor_command_sequencer.sv
// sensor command sequencer: power-up, calibration, conversions, result reads
// assumes a two-wire bus on scl/sda pins, and measurement values from
// same-clock front-end logic, valid when a conversion phase ends
`timescale 1ns/1ps
`default_nettype none
`include "sensor_seq_params.svh"
// Function
// RULE1: start power-up sequence by itself after reset
// RULE2: power-up sequence lasts about 400 us
// RULE3: ready flag set when power-up completes
// RULE4: one calibration per reset, then sleep
// RULE5: sleep, run command, return to sleep
// RULE6: pressure always preceded by temperature
// RULE7: results held in storage through sleep
// RULE8: command 0x06 aborts everything and resets
// RULE9: soft reset clears storage, reruns power-up
// RULE10: conversion byte is 010, oversampling, channel
// RULE11: channel 00 both, 10 temperature only
// RULE12: oversampling code sets decimation 4096 down to 128
// RULE13: illegal channel or oversampling fails conversion
// RULE14: conversion time follows oversampling and channel
// RULE15: compensation setting picks compensated or raw results
// RULE16: altitude refreshed when pressure measurement completes
// RULE17: 0x10 returns temperature and pressure
// RULE18: 0x11 returns temperature and altitude
// RULE19: 0x30 returns pressure only
// RULE20: 24-bit words, MSB first, top nibble unused
// RULE21: temperature is 20-bit signed hundredths degree
// RULE22: pressure is 20-bit hundredths pascal
// RULE23: altitude is 20-bit signed hundredths metre
// RULE24: bus address 1110110, 0xEC write, 0xED read
// RULE25: command frame, then separate 3/6-byte read frame
// RULE26: host waits conversion time before reading
// RULE27: unknown command bytes are ignored
module sensor_command_sequencer import sensor_seq_pkg::*; #(
  parameter int unsigned PWRUP_CYC = `US_TO_CYC(`PWRUP_TIME_US),
  parameter int unsigned TEMP_CYC [6] = '{
    `US_TO_CYC(`T_TEMP_US_0), `US_TO_CYC(`T_TEMP_US_1), `US_TO_CYC(`T_TEMP_US_2),
    `US_TO_CYC(`T_TEMP_US_3), `US_TO_CYC(`T_TEMP_US_4), `US_TO_CYC(`T_TEMP_US_5)},
  parameter int unsigned BOTH_CYC [6] = '{
    `US_TO_CYC(`T_BOTH_US_0), `US_TO_CYC(`T_BOTH_US_1), `US_TO_CYC(`T_BOTH_US_2),
    `US_TO_CYC(`T_BOTH_US_3), `US_TO_CYC(`T_BOTH_US_4), `US_TO_CYC(`T_BOTH_US_5)}
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic comp_setting_i,
  input wire logic [19:0] temp_comp_i,
  input wire logic [19:0] temp_raw_i,
  input wire logic [19:0] press_comp_i,
  input wire logic [19:0] press_raw_i,
  input wire logic [19:0] alt_i,
  output logic power_up_done_flag_o,
  output logic calibrate_o,
  output logic sleep_o,
  output logic meas_temp_o,
  output logic meas_press_o,
  output logic conv_fail_o,
  output logic [12:0] decim_rate_o
);

  function automatic logic is_conv(input logic [7:0] b);
    return b[7:5] == `CONV_PREFIX; // RULE10
  endfunction : is_conv

  function automatic logic conv_legal(input logic [7:0] b);
    logic chnl_ok;
    chnl_ok = (b[1:0] == `CHNL_BOTH) || (b[1:0] == `CHNL_TEMP); // RULE11
    return chnl_ok && (b[4:2] <= `OVS_MAX_CODE); // RULE13
  endfunction : conv_legal

  function automatic read_sel_t read_sel(input logic [7:0] b, input read_sel_t keep);
    read_sel_t s;
    unique case (b)
      `CMD_RD_TP: s = SEL_TP; // RULE17
      `CMD_RD_TA: s = SEL_TA; // RULE18
      `CMD_RD_P: s = SEL_P; // RULE19
      `CMD_RD_A: s = SEL_A;
      `CMD_RD_T: s = SEL_T;
      default: s = keep; // RULE27
    endcase
    return s;
  endfunction : read_sel

  function automatic logic [23:0] pad(input logic [19:0] v);
    return {`RES_PAD, v}; // RULE20
  endfunction : pad

  // pin synchronisation and bus event detection
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;

  bit_sync #(
    .W(2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({scl_i, sda_i}),
    .q_o({scl_s, sda_s})
  );

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // sequencer state
  seq_state_t st_q, st_d;
  logic [`CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] ovs_q, ovs_d;
  logic both_q, both_d;
  logic [19:0] temp_q, temp_d;
  logic [19:0] press_q, press_d;
  logic [19:0] alt_q, alt_d;
  read_sel_t sel_q, sel_d;
  logic ready_q, ready_d;
  logic cal_q, cal_d;
  logic fail_q, fail_d;
  logic [12:0] decim_q, decim_d;

  // link state
  link_state_t ln_q, ln_d;
  logic [2:0] bit_q, bit_d;
  logic [6:0] sh_q, sh_d;
  logic oe_n_q, oe_n_d;
  logic ack_on_q, ack_on_d;
  logic rw_q, rw_d;
  logic [1:0] word_q, word_d;
  logic [1:0] lane_q, lane_d;
  logic stb_q, stb_d;
  logic [7:0] cmd_q, cmd_d;

  logic [`CNT_W-1:0] conv_limit;

  conv_duration #(
    .TEMP_CYC(TEMP_CYC),
    .BOTH_CYC(BOTH_CYC)
  ) u_dur (
    .ovs_i(ovs_q),
    .press_phase_i(st_q == ST_CONV_P),
    .limit_o(conv_limit)
  );

  // byte presented on a read frame, chosen by the last read command
  logic [23:0] word_v;
  logic [7:0] cur_byte;

  always_comb begin
    word_v = 24'h000000;
    if (word_q == 2'h0) begin
      unique case (sel_q)
        SEL_TP, SEL_TA, SEL_T: word_v = pad(temp_q); // RULE21
        SEL_P: word_v = pad(press_q); // RULE22
        SEL_A: word_v = pad(alt_q); // RULE23
        default: word_v = 24'h000000;
      endcase
    end else if (word_q == 2'h1) begin
      unique case (sel_q)
        SEL_TP: word_v = pad(press_q); // RULE17
        SEL_TA: word_v = pad(alt_q); // RULE18
        default: word_v = 24'h000000;
      endcase
    end
    unique case (lane_q)
      2'h0: cur_byte = word_v[23:16]; // RULE20
      2'h1: cur_byte = word_v[15:8];
      default: cur_byte = word_v[7:0];
    endcase
  end

  // sequencer next state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    ovs_d = ovs_q;
    both_d = both_q;
    temp_d = temp_q;
    press_d = press_q;
    alt_d = alt_q;
    sel_d = sel_q;
    ready_d = ready_q;
    cal_d = 1'b0;
    fail_d = fail_q;
    decim_d = decim_q;
    if (stb_q && cmd_q == `CMD_SOFT_RST) begin
      st_d = ST_INIT; // RULE8
      cnt_d = '0;
      temp_d = '0; // RULE9
      press_d = '0;
      alt_d = '0;
      sel_d = SEL_NONE;
      ready_d = 1'b0;
      fail_d = 1'b0;
      ovs_d = 3'h0;
      both_d = 1'b0;
      decim_d = `DECIM_BASE;
    end else begin
      if (stb_q) begin
        sel_d = read_sel(cmd_q, sel_q); // RULE25
      end
      unique case (st_q)
        ST_INIT: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == `CNT_W'(PWRUP_CYC - 1)) begin
            st_d = ST_CAL; // RULE2
            cnt_d = '0;
          end
        end
        ST_CAL: begin
          cal_d = 1'b1; // RULE4
          ready_d = 1'b1; // RULE3
          st_d = ST_SLEEP;
        end
        ST_SLEEP: begin
          if (stb_q && is_conv(cmd_q)) begin
            if (conv_legal(cmd_q)) begin
              st_d = ST_CONV_T; // RULE5
              cnt_d = '0;
              ovs_d = cmd_q[4:2];
              both_d = cmd_q[1:0] == `CHNL_BOTH; // RULE11
              decim_d = `DECIM_BASE >> cmd_q[4:2]; // RULE12
              fail_d = 1'b0;
            end else begin
              fail_d = 1'b1; // RULE13
            end
          end
        end
        ST_CONV_T: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == conv_limit) begin
            cnt_d = '0;
            temp_d = comp_setting_i ? temp_comp_i : temp_raw_i; // RULE15
            st_d = both_q ? ST_CONV_P : ST_SLEEP; // RULE6
          end
        end
        ST_CONV_P: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == conv_limit) begin
            cnt_d = '0;
            press_d = comp_setting_i ? press_comp_i : press_raw_i; // RULE15
            alt_d = alt_i; // RULE16
            st_d = ST_SLEEP; // RULE5
          end
        end
      endcase
    end
  end

  // rst_i is the power-on reset: it lands in the power-up sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_INIT; // RULE1
      cnt_q <= '0;
      ovs_q <= 3'h0;
      both_q <= 1'b0;
      temp_q <= '0;
      press_q <= '0;
      alt_q <= '0;
      sel_q <= SEL_NONE;
      ready_q <= 1'b0;
      cal_q <= 1'b0;
      fail_q <= 1'b0;
      decim_q <= `DECIM_BASE;
    end else if (ce_i) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ovs_q <= ovs_d;
      both_q <= both_d;
      temp_q <= temp_d; // RULE7
      press_q <= press_d;
      alt_q <= alt_d;
      sel_q <= sel_d;
      ready_q <= ready_d;
      cal_q <= cal_d;
      fail_q <= fail_d;
      decim_q <= decim_d;
    end
  end

  // bus slave next state; the address byte is acknowledged only on a match, every written byte is acknowledged, decoding happens later
  always_comb begin
    ln_d = ln_q;
    bit_d = bit_q;
    sh_d = sh_q;
    oe_n_d = oe_n_q;
    ack_on_d = ack_on_q;
    rw_d = rw_q;
    word_d = word_q;
    lane_d = lane_q;
    stb_d = 1'b0;
    cmd_d = cmd_q;
    if (start_c) begin
      ln_d = I_ADDR;
      bit_d = 3'h0;
      oe_n_d = 1'b1;
      ack_on_d = 1'b0;
    end else if (stop_c) begin
      ln_d = I_IDLE;
      oe_n_d = 1'b1;
    end else begin
      unique case (ln_q)
        I_IDLE: oe_n_d = 1'b1;
        I_ADDR, I_WR: begin
          if (scl_rise) begin
            sh_d = {sh_q[5:0], sda_s};
            bit_d = bit_q + 3'h1;
            if (bit_q == `BIT_LAST) begin
              if (ln_q == I_WR) begin
                stb_d = 1'b1;
                cmd_d = {sh_q, sda_s};
                ln_d = I_ACK_W;
              end else if (sh_q == `DEV_ADDR) begin
                rw_d = sda_s; // RULE24
                word_d = 2'h0;
                lane_d = 2'h0;
                ln_d = I_ACK_A;
              end else begin
                ln_d = I_IDLE;
              end
            end
          end
        end
        I_ACK_A, I_ACK_W: begin
          if (scl_fall) begin
            if (!ack_on_q) begin
              oe_n_d = 1'b0;
              ack_on_d = 1'b1;
            end else begin
              ack_on_d = 1'b0;
              bit_d = 3'h0;
              if (ln_q == I_ACK_A && rw_q) begin
                ln_d = I_RD; // RULE25
                oe_n_d = cur_byte[7];
              end else begin
                ln_d = I_WR;
                oe_n_d = 1'b1;
              end
            end
          end
        end
        I_RD: begin
          if (scl_rise) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == `BIT_LAST) begin
              ln_d = I_ACK_R;
            end
          end
          if (scl_fall) begin
            oe_n_d = cur_byte[`BIT_LAST - bit_q]; // RULE20
          end
        end
        I_ACK_R: begin
          if (scl_fall) begin
            oe_n_d = 1'b1;
          end
          if (scl_rise) begin
            if (!sda_s) begin
              ln_d = I_RD_NEXT;
              if (lane_q == `LANE_LAST) begin
                lane_d = 2'h0;
                word_d = (word_q == `WORD_DONE) ? word_q : word_q + 2'h1;
              end else begin
                lane_d = lane_q + 2'h1;
              end
            end else begin
              ln_d = I_IDLE;
            end
          end
        end
        I_RD_NEXT: begin
          if (scl_fall) begin
            oe_n_d = cur_byte[7];
            ln_d = I_RD;
          end
        end
        default: begin
          ln_d = I_IDLE;
          oe_n_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      ln_q <= I_IDLE;
      bit_q <= 3'h0;
      sh_q <= 7'h00;
      oe_n_q <= 1'b1;
      ack_on_q <= 1'b0;
      rw_q <= 1'b0;
      word_q <= 2'h0;
      lane_q <= 2'h0;
      stb_q <= 1'b0;
      cmd_q <= 8'h00;
    end else if (ce_i) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      ln_q <= ln_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      oe_n_q <= oe_n_d;
      ack_on_q <= ack_on_d;
      rw_q <= rw_d;
      word_q <= word_d;
      lane_q <= lane_d;
      stb_q <= stb_d;
      cmd_q <= cmd_d;
    end
  end

  // status outputs are registered copies of the state
  logic sleep_q;
  logic meas_t_q;
  logic meas_p_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_q <= 1'b0;
      meas_t_q <= 1'b0;
      meas_p_q <= 1'b0;
    end else if (ce_i) begin
      sleep_q <= st_d == ST_SLEEP;
      meas_t_q <= st_d == ST_CONV_T;
      meas_p_q <= st_d == ST_CONV_P;
    end
  end

  // open-drain: the pin only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_n_o = oe_n_q;
  assign power_up_done_flag_o = ready_q;
  assign calibrate_o = cal_q;
  assign sleep_o = sleep_q;
  assign meas_temp_o = meas_t_q;
  assign meas_press_o = meas_p_q;
  assign conv_fail_o = fail_q;
  assign decim_rate_o = decim_q;

endmodule : sensor_command_sequencer
`default_nettype wire

//--- sensor_command_sequencer_monitor.sv
// checker for the sensor command sequencer: start-up, phases, pin timing
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module sensor_command_sequencer_monitor #(
  parameter int unsigned PWRUP_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_oe_n_o,
  input wire logic power_up_done_flag_o,
  input wire logic calibrate_o,
  input wire logic sleep_o,
  input wire logic meas_temp_o,
  input wire logic meas_press_o,
  input wire logic conv_fail_o,
  input wire logic [12:0] decim_rate_o
);
  int unsigned low_cnt_q;
  int unsigned low_cnt_d;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // cycles spent without the ready flag since reset or soft reset
  always_comb begin
    low_cnt_d = power_up_done_flag_o ? 0 : low_cnt_q + 1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) low_cnt_q <= 0;
    else low_cnt_q <= low_cnt_d;
  end

  a_pwrup_bound: assert property (low_cnt_q <= PWRUP_CYC + 4)
    else $error("power-up sequence too long");
  a_pwrup_length: assert property ($rose(power_up_done_flag_o) |-> low_cnt_q >= PWRUP_CYC)
    else $error("ready flag raised before power-up count ran out");
  a_cal_sets_flag: assert property (calibrate_o |-> ##[0:1] power_up_done_flag_o)
    else $error("calibration did not set ready flag");
  a_cal_once: assert property (power_up_done_flag_o && $past(power_up_done_flag_o) |-> !calibrate_o)
    else $error("calibration repeated while ready");
  a_cal_pulse: assert property (calibrate_o |=> !calibrate_o [*8])
    else $error("calibration pulse repeated");
  a_ready_first: assert property (!power_up_done_flag_o |-> !sleep_o && !meas_temp_o && !meas_press_o)
    else $error("sleep or measure before ready");
  a_one_phase: assert property (meas_temp_o || meas_press_o |-> !sleep_o && !(meas_temp_o && meas_press_o))
    else $error("phases overlap");
  a_temp_first: assert property ($rose(meas_press_o) |-> $past(meas_temp_o))
    else $error("pressure phase without temperature phase");
  a_back_to_sleep: assert property (($fell(meas_temp_o) && !meas_press_o) || $fell(meas_press_o) |-> ##[0:1] sleep_o)
    else $error("no return to sleep after conversion");
  a_fail_idle: assert property ($rose(conv_fail_o) |-> sleep_o && !meas_temp_o)
    else $error("failed conversion started a phase");
  a_decim_legal: assert property (decim_rate_o inside {13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0100, 13'h0080})
    else $error("decimation rate not a legal value");
  a_sda_scl_low: assert property (!$stable(sda_oe_n_o) |-> !scl_i)
    else $error("data pin changed while bus clock high");
endmodule : sensor_command_sequencer_monitor

bind sensor_command_sequencer sensor_command_sequencer_monitor #(.PWRUP_CYC(PWRUP_CYC)) u_monitor (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .scl_i(scl_i),
  .sda_oe_n_o(sda_oe_n_o),
  .power_up_done_flag_o(power_up_done_flag_o),
  .calibrate_o(calibrate_o),
  .sleep_o(sleep_o),
  .meas_temp_o(meas_temp_o),
  .meas_press_o(meas_press_o),
  .conv_fail_o(conv_fail_o),
  .decim_rate_o(decim_rate_o)
);
`default_nettype wire

//--- sensor_host_model.sv
// bus master model of the host: start, stop, byte write and byte read
// assumes the bench resolves the data line with a pull-up; 160 ns bit time
`timescale 1ns/1ps
`default_nettype none
module sensor_host_model (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // bus clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic start();
    sda_o = 1'b1;
    scl_o = 1'b1;
    #80 sda_o = 1'b0;
    #80 scl_o = 1'b0;
  endtask : start

  task automatic stop();
    #20 sda_o = 1'b0;
    #20 scl_o = 1'b1;
    #40 sda_o = 1'b1;
    #120;
  endtask : stop

  // data changes only while the bus clock is low
  task automatic bit_cyc(input logic v, output logic s);
    #40 sda_o = v;
    #40 scl_o = 1'b1;
    #40 s = sda_i;
    #40 scl_o = 1'b0;
  endtask : bit_cyc

  task automatic put(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_cyc(d[i], ack);
    bit_cyc(1'b1, ack);
  endtask : put

  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
    bit_cyc(last, s);
  endtask : get
endmodule : sensor_host_model
`default_nettype wire

//--- sensor_seq_params.svh
// constants of the sensor command sequencer: commands, codes, times
// assumes a 200 MHz core clock; times are kept in microseconds
`ifndef SENSOR_SEQ_PARAMS_SVH
`define SENSOR_SEQ_PARAMS_SVH

`define CLK_PERIOD_NS 5
// all times round down to whole cycles
`define US_TO_CYC(t) (((t) * 1000) / `CLK_PERIOD_NS)

`define PWRUP_TIME_US 400

// temperature-only time per oversampling code 000..101
`define T_TEMP_US_0 65600
`define T_TEMP_US_1 32800
`define T_TEMP_US_2 16400
`define T_TEMP_US_3 8200
`define T_TEMP_US_4 4100
`define T_TEMP_US_5 2100
// temperature plus pressure time per oversampling code
`define T_BOTH_US_0 131100
`define T_BOTH_US_1 65600
`define T_BOTH_US_2 32800
`define T_BOTH_US_3 16400
`define T_BOTH_US_4 8200
`define T_BOTH_US_5 4100

`define CMD_SOFT_RST 8'h06
`define CMD_RD_TP 8'h10
`define CMD_RD_TA 8'h11
`define CMD_RD_P 8'h30
`define CMD_RD_A 8'h31
`define CMD_RD_T 8'h32
`define CONV_PREFIX 3'h2
`define CHNL_BOTH 2'h0
`define CHNL_TEMP 2'h2
`define OVS_MAX_CODE 3'h5
`define DECIM_BASE 13'h1000

`define DEV_ADDR 7'h76
`define BIT_LAST 3'h7
`define LANE_LAST 2'h2
`define WORD_DONE 2'h2
`define RES_PAD 4'h0
`define CNT_W 24

`endif

//--- sensor_seq_pkg.sv
// types shared by the sensor command sequencer and its helpers
// assumes sensor_seq_params.svh for all numeric constants
`default_nettype none
package sensor_seq_pkg;

  typedef enum logic [4:0] {
    ST_INIT = 5'h01,
    ST_CAL = 5'h02,
    ST_SLEEP = 5'h04,
    ST_CONV_T = 5'h08,
    ST_CONV_P = 5'h10
  } seq_state_t;

  typedef enum logic [7:0] {
    I_IDLE = 8'h01,
    I_ADDR = 8'h02,
    I_ACK_A = 8'h04,
    I_WR = 8'h08,
    I_ACK_W = 8'h10,
    I_RD = 8'h20,
    I_ACK_R = 8'h40,
    I_RD_NEXT = 8'h80
  } link_state_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_TP = 3'h1,
    SEL_TA = 3'h2,
    SEL_P = 3'h3,
    SEL_A = 3'h4,
    SEL_T = 3'h5
  } read_sel_t;

endpackage : sensor_seq_pkg
`default_nettype wire

//--- tb_sensor_command_sequencer.sv
// self-checking bench of the sensor command sequencer
// assumes sensor_host_model on the bus pins and shortened phase counts
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_command_sequencer;
  localparam int unsigned PW = 20;
  localparam int unsigned TC [6] = '{12, 10, 8, 6, 4, 2};
  localparam int unsigned BC [6] = '{24, 20, 16, 12, 8, 4};
  localparam logic [7:0] BAD [4] = '{8'h49, 8'h4B, 8'h58, 8'h5C};
  logic clk_i, rst_i, comp, host_scl, host_sda, ack;
  logic dut_sda, dut_oe_n, flag, cal, slp, mt, mp, fail;
  logic [12:0] decim;
  logic [19:0] t_c, t_r, p_c, p_r, alt;
  logic [47:0] rdat;
  logic [7:0] b;
  wire logic sda_line;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int cal_cnt = 0;
  int tcnt = 0;
  int pcnt = 0;
  int tlen = 0;
  int plen = 0;

  // open drain with pull-up: released line reads high
  assign sda_line = host_sda & (dut_oe_n | dut_sda);

  sensor_host_model i_host (.scl_o(host_scl), .sda_o(host_sda), .sda_i(sda_line));

  sensor_command_sequencer #(.PWRUP_CYC(PW), .TEMP_CYC(TC), .BOTH_CYC(BC)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .scl_i(host_scl), .sda_i(sda_line),
    .sda_o(dut_sda), .sda_oe_n_o(dut_oe_n), .comp_setting_i(comp),
    .temp_comp_i(t_c), .temp_raw_i(t_r), .press_comp_i(p_c), .press_raw_i(p_r), .alt_i(alt),
    .power_up_done_flag_o(flag), .calibrate_o(cal), .sleep_o(slp), .meas_temp_o(mt),
    .meas_press_o(mp), .conv_fail_o(fail), .decim_rate_o(decim)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // phase lengths and calibration pulses seen at the pins
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cal) cal_cnt <= cal_cnt + 1;
    if (mt) tcnt <= tcnt + 1;
    else if (tcnt != 0) begin
      tlen <= tcnt;
      tcnt <= 0;
    end
    if (mp) pcnt <= pcnt + 1;
    else if (pcnt != 0) begin
      plen <= pcnt;
      pcnt <= 0;
    end
    if (cyc == 60000) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one command byte in a write frame, then the host waits out any conversion
  task automatic send(input logic [7:0] c);
    i_host.start();
    i_host.put(8'hEC, ack);
    chk(ack, 0);
    i_host.put(c, ack);
    chk(ack, 0);
    i_host.stop();
    repeat (40) @(posedge clk_i);
    #1;
  endtask : send

  task automatic fetch(input int n);
    i_host.start();
    i_host.put(8'hED, ack);
    chk(ack, 0);
    rdat = '0;
    for (int i = 0; i < n; i++) begin
      i_host.get(i == n - 1, b);
      rdat = {rdat[39:0], b};
    end
    i_host.stop();
  endtask : fetch

  task automatic wait_ready();
    for (int i = 0; i < PW + 20 && flag !== 1'b1; i++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    #1;
  endtask : wait_ready

  initial begin
    rst_i = 1'b1;
    comp = 1'b1;
    t_c = 20'hFFC02;
    t_r = 20'h00A5C;
    p_c = 20'h18A9E;
    p_r = 20'h0ABCD;
    alt = 20'hFEC78;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk(flag, 0);
    wait_ready();
    chk({slp, flag, cal_cnt[3:0]}, {2'b11, 4'h1});
    i_host.start();
    i_host.put(8'hEE, ack);
    i_host.stop();
    chk(ack, 1);
    send(8'h54);
    chk({tlen[7:0], plen[7:0]}, {8'd2, 8'd2});
    comp = 1'b0;
    send(8'h10);
    fetch(6);
    chk(rdat, {4'h0, t_c, 4'h0, p_c});
    send(8'h11);
    fetch(6);
    chk(rdat, {4'h0, t_c, 4'h0, alt});
    send(8'h30);
    fetch(3);
    chk(rdat[23:0], {4'h0, p_c});
    for (int o = 0; o < 6; o++) begin
      tlen = 0;
      plen = 0;
      send({3'b010, o[2:0], 2'b10});
      chk({decim, tlen[7:0], plen[7:0]}, {13'h1000 >> o, 8'(TC[o]), 8'h0});
    end
    send(8'h10);
    fetch(6);
    chk(rdat, {4'h0, t_r, 4'h0, p_c});
    for (int k = 0; k < 4; k++) begin
      tlen = 0;
      send(BAD[k]);
      chk({fail, slp, tlen[7:0]}, {2'b11, 8'h0});
    end
    tlen = 0;
    plen = 0;
    send(8'h50);
    chk({fail, tlen[7:0], plen[7:0]}, {1'b0, 8'd4, 8'd4});
    send(8'h10);
    fetch(6);
    chk(rdat, {4'h0, t_r, 4'h0, p_r});
    // an unknown byte must leave the read selection and results alone
    send(8'h30);
    send(8'h07);
    fetch(3);
    chk({slp, flag, rdat[23:0]}, {2'b11, 4'h0, p_r});
    send(8'h31);
    fetch(3);
    chk(rdat[23:0], {4'h0, alt});
    send(8'h32);
    fetch(3);
    chk(rdat[23:0], {4'h0, t_r});
    send(8'h06);
    wait_ready();
    chk({cal_cnt[3:0], flag, slp, decim}, {4'h2, 2'b11, 13'h1000});
    send(8'h10);
    fetch(6);
    chk(rdat, 48'h0);
    complete_run();
  end
endmodule : tb_sensor_command_sequencer
`default_nettype wire
